// file: hw/gmri_top.sv
/*
 gmri_top: register interface of a two-finger gripper behind a Modbus RTU
 byte stream; parses read and multiple-write frames, holds the command
 block and answers with the status block.
 Assumes a same-clock serial front end that delivers bytes, flags the
 end-of-frame silence, and takes reply bytes with a ready handshake.
*/
// Summary of operation
// - a three-word status reply carries byte count six, two bytes a word.
// - word one holds the status byte on top and a zero reserved byte.
// - activation flag reads set while the stored action request sets it, go-to only while it sets both.
// - object state reads 0 moving, 2 contact on closing, 3 arrived.
// - word two holds the fault byte and the echo of the last position.
// - word three holds finger position on top and motor current below.
// - after a contact stop the position shows the real stopping point.
// - on full opening a small nonzero position may stand with arrival.
// - action byte 09 keeps the gripper active and starts the move.
// - position request 0 opens fully and 255 closes fully.
// - the third command word holds speed on top and force below.
// - a write is answered by id, function, start address and count.
// - every frame in and out ends with its check word.
`timescale 1ns/1ps
`default_nettype none
module gmri_top #(
  parameter logic [7:0] SLAVE_ID = gmri_pkg::SLAVE_ID_DEFAULT
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // request bytes from the serial front end
  input wire gmri_pkg::gmri_rx_t rx,
  // reply bytes to the serial front end
  input wire logic tx_ready,
  output gmri_pkg::gmri_tx_t tx,
  // command block to the motion core
  output gmri_pkg::gmri_cmd_t cmd,
  output logic cmd_strobe,
  // live state of the motion core
  input wire gmri_pkg::gmri_mech_t mech
);
  typedef struct packed {
    gmri_pkg::gmri_phase_t phase;
    gmri_pkg::gmri_resp_t kind;
    logic [4:0] rx_idx;
    logic ignore;
    logic [7:0] func;
    logic [15:0] addr;
    logic [15:0] count;
    logic [7:0] bytecount;
    logic [47:0] stage;
    logic [4:0] tx_idx;
    logic [4:0] tx_len;
    logic [1:0] addr_ofs;
    logic [7:0] exc_code;
    logic [47:0] snap;
    logic [7:0] echo;
    gmri_pkg::gmri_cmd_t cmd;
    logic cmd_strobe;
    gmri_pkg::gmri_tx_t tx;
  } gmri_state_t;

  gmri_state_t st;
  gmri_state_t next_st;
  logic [15:0] rx_crc;
  logic [15:0] tx_crc;
  logic act_flag;
  logic goto_flag;
  logic [1:0] obj_state;
  logic [15:0] status_w0;
  logic [15:0] status_w1;
  logic [15:0] status_w2;
  logic rx_take;
  logic tx_accept;
  logic tx_done;
  logic tx_crc_init;

  // flags follow the stored request bits
  assign act_flag = st.cmd.action_request_word[8 + gmri_pkg::ACT_BIT];
  assign goto_flag = act_flag &
    st.cmd.action_request_word[8 + gmri_pkg::GTO_BIT];

  // object state from the motion core
  always_comb begin
    obj_state = gmri_pkg::OBJ_MOVING;
    if (goto_flag && !mech.moving) begin
      if (mech.arrived) begin
        obj_state = gmri_pkg::OBJ_ARRIVED;
      end else if (mech.contact_closing) begin
        obj_state = gmri_pkg::OBJ_CONTACT_CLOSE;
      end else if (mech.contact_opening) begin
        obj_state = gmri_pkg::OBJ_CONTACT_OPEN;
      end
    end
  end

  // status byte on top, reserved byte zero
  assign status_w0 = {obj_state, mech.activation_state, goto_flag,
                      2'b00, act_flag, gmri_pkg::RESERVED_BYTE};
  assign status_w1 = {mech.fault, st.echo};
  // raw position, never replaced by the target
  assign status_w2 = {mech.position, mech.current};

  assign rx_take = (st.phase == gmri_pkg::PH_RX) && rx.valid;
  assign tx_accept = (st.phase == gmri_pkg::PH_SEND) && tx_ready;
  assign tx_done = tx_accept && (st.tx_idx == st.tx_len - 5'h01);

  function automatic logic [15:0] snap_word(input logic [47:0] s,
                                            input logic [1:0] w);
    logic [15:0] r;
    case (w)
      2'h0: r = s[47:32];
      2'h1: r = s[31:16];
      default: r = s[15:0];
    endcase
    return r;
  endfunction : snap_word

  function automatic logic [7:0] resp_byte(input gmri_state_t s,
                                           input logic [15:0] c,
                                           input logic [7:0] id);
    logic [7:0] r;
    logic [4:0] k;
    logic [15:0] w;
    r = 8'h00;
    k = s.tx_idx - 5'h03;
    // two bytes a word: word index is the byte index over two
    w = snap_word(s.snap, 2'(s.addr_ofs + k[2:1]));
    if (s.tx_idx == s.tx_len - 5'h02) begin
      r = c[7:0];
    end else if (s.tx_idx == s.tx_len - 5'h01) begin
      r = c[15:8];
    end else if (s.tx_idx == 5'h00) begin
      r = id;
    end else if (s.tx_idx == 5'h01) begin
      r = (s.kind == gmri_pkg::RESP_EXC) ? (s.func | gmri_pkg::EXC_FLAG)
                                         : s.func;
    end else begin
      case (s.kind)
        gmri_pkg::RESP_READ: begin
          if (s.tx_idx == 5'h02) begin
            r = s.bytecount;
          end else begin
            r = k[0] ? w[7:0] : w[15:8];
          end
        end
        gmri_pkg::RESP_WRITE: begin
          case (s.tx_idx)
            5'h02: r = s.addr[15:8];
            5'h03: r = s.addr[7:0];
            5'h04: r = s.count[15:8];
            default: r = s.count[7:0];
          endcase
        end
        default: r = s.exc_code;
      endcase
    end
    return r;
  endfunction : resp_byte

  always_comb begin
    logic [16:0] read_end;
    logic count_ok;
    logic frame_ok;
    logic [2:0] sidx;
    read_end = {1'b0, st.addr} + {1'b0, st.count};
    count_ok = (st.count != 16'h0000) && (st.count <= gmri_pkg::BLOCK_WORDS);
    frame_ok = !st.ignore && (st.rx_idx >= gmri_pkg::MIN_FRAME_LEN) &&
               (rx_crc == 16'h0000);
    sidx = 3'(st.rx_idx - gmri_pkg::DATA_FIRST_IDX);
    next_st = st;
    next_st.cmd_strobe = 1'b0;
    tx_crc_init = 1'b0;
    case (st.phase)
      gmri_pkg::PH_RX: begin
        if (rx.valid) begin
          case (st.rx_idx)
            5'h00: next_st.ignore = (rx.data != SLAVE_ID);
            5'h01: next_st.func = rx.data;
            5'h02: next_st.addr[15:8] = rx.data;
            5'h03: next_st.addr[7:0] = rx.data;
            5'h04: next_st.count[15:8] = rx.data;
            5'h05: next_st.count[7:0] = rx.data;
            5'h06: next_st.bytecount = rx.data;
            default: begin
              if (st.rx_idx < gmri_pkg::DATA_END_IDX) begin
                next_st.stage[8 * (5 - int'(sidx)) +: 8] = rx.data;
              end
            end
          endcase
          if (st.rx_idx != gmri_pkg::IDX_MAX) begin
            next_st.rx_idx = st.rx_idx + 5'h01;
          end
        end else if (rx.frame_end) begin
          next_st.rx_idx = 5'h00;
          next_st.ignore = 1'b0;
          next_st.tx_idx = 5'h00;
          next_st.snap = {status_w0, status_w1, status_w2};
          next_st.addr_ofs = 2'(st.addr - gmri_pkg::GRIPPER_STATUS_OFS);
          // a frame with a bad check word is dropped silently
          if (frame_ok) begin
            if (st.func == gmri_pkg::FC_READ_HOLDING) begin
              if (st.rx_idx == gmri_pkg::READ_REQ_LEN) begin
                next_st.phase = gmri_pkg::PH_LOAD;
                tx_crc_init = 1'b1;
                if (count_ok && st.addr >= gmri_pkg::GRIPPER_STATUS_OFS &&
                    read_end <= {1'b0, gmri_pkg::POSITION_CURRENT_OFS} +
                    17'h00001) begin
                  next_st.kind = gmri_pkg::RESP_READ;
                  next_st.bytecount = {st.count[6:0], 1'b0};
                  next_st.tx_len = gmri_pkg::READ_RESP_HDR +
                                   {st.count[3:0], 1'b0};
                end else begin
                  next_st.kind = gmri_pkg::RESP_EXC;
                  next_st.exc_code = gmri_pkg::EXC_ILLEGAL_ADDR;
                  next_st.tx_len = gmri_pkg::EXC_RESP_LEN;
                end
              end
            end else if (st.func == gmri_pkg::FC_WRITE_MULTI) begin
              if (st.rx_idx == gmri_pkg::WRITE_HDR_LEN + st.bytecount[4:0]
                  && st.bytecount == {st.count[6:0], 1'b0}) begin
                next_st.phase = gmri_pkg::PH_LOAD;
                tx_crc_init = 1'b1;
                if (count_ok && st.addr == gmri_pkg::CMD_BASE_ADDR) begin
                  next_st.cmd.action_request_word = st.stage[47:32];
                  if (st.count >= 16'h0002) begin
                    next_st.cmd.position_request_word = st.stage[31:16];
                    next_st.echo = st.stage[23:16];
                  end
                  if (st.count == gmri_pkg::BLOCK_WORDS) begin
                    next_st.cmd.speed_force_word = st.stage[15:0];
                  end
                  next_st.cmd_strobe = 1'b1;
                  next_st.kind = gmri_pkg::RESP_WRITE;
                  next_st.tx_len = gmri_pkg::WRITE_RESP_LEN;
                end else begin
                  next_st.kind = gmri_pkg::RESP_EXC;
                  next_st.exc_code = gmri_pkg::EXC_ILLEGAL_ADDR;
                  next_st.tx_len = gmri_pkg::EXC_RESP_LEN;
                end
              end
            end else begin
              next_st.phase = gmri_pkg::PH_LOAD;
              tx_crc_init = 1'b1;
              next_st.kind = gmri_pkg::RESP_EXC;
              next_st.exc_code = gmri_pkg::EXC_ILLEGAL_FUNC;
              next_st.tx_len = gmri_pkg::EXC_RESP_LEN;
            end
          end
        end
      end
      gmri_pkg::PH_LOAD: begin
        // one idle cycle lets the check register settle before the tail
        next_st.tx.valid = 1'b1;
        next_st.tx.data = resp_byte(st, tx_crc, SLAVE_ID);
        next_st.phase = gmri_pkg::PH_SEND;
      end
      gmri_pkg::PH_SEND: begin
        if (tx_ready) begin
          next_st.tx.valid = 1'b0;
          next_st.tx_idx = st.tx_idx + 5'h01;
          next_st.phase = tx_done ? gmri_pkg::PH_RX : gmri_pkg::PH_LOAD;
        end
      end
      default: next_st.phase = gmri_pkg::PH_RX;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st <= '0;
      st.phase <= gmri_pkg::PH_RX;
      st.kind <= gmri_pkg::RESP_READ;
      st.cmd <= {3{gmri_pkg::CMD_RESET}};
    end else begin
      st <= next_st;
    end
  end

  // check word over request bytes, zero residue when intact
  gmri_crc16 u_rx_crc (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .init(rx.frame_end || tx_done),
    .update(rx_take),
    .data(rx.data),
    .crc(rx_crc)
  );

  // check word over reply bytes, tail bytes excluded
  gmri_crc16 u_tx_crc (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .init(tx_crc_init),
    .update(tx_accept && (st.tx_idx < st.tx_len - 5'h02)),
    .data(st.tx.data),
    .crc(tx_crc)
  );

  assign tx = st.tx;
  assign cmd = st.cmd;
  assign cmd_strobe = st.cmd_strobe;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_write_done;
    cmd_strobe && cmd.action_request_word[15:8] == 8'h09;
  endsequence

  chk_read_bytecount: assert property (
    tx.valid && st.kind == gmri_pkg::RESP_READ && st.tx_idx == 5'h02
    |-> tx.data == {st.count[6:0], 1'b0})
    else $error("status reply byte count wrong");
  chk_status_reserved: assert property (
    st.phase != gmri_pkg::PH_RX && st.kind == gmri_pkg::RESP_READ
    |-> st.snap[39:32] == 8'h00)
    else $error("reserved status byte not zero");
  chk_goto_flags: assert property (
    s_write_done |-> status_w0[8] && status_w0[11])
    else $error("activation or go-to flag not set");
  chk_obj_arrived: assert property (
    goto_flag && !mech.moving && mech.arrived |-> status_w0[15:14] == 2'h3)
    else $error("arrival not reported");
  chk_obj_contact: assert property (
    goto_flag && !mech.arrived && mech.contact_closing && !mech.moving
    |-> status_w0[15:14] == 2'h2)
    else $error("closing contact not reported");
  chk_echo_update: assert property (
    $changed(st.echo) |-> cmd_strobe && st.echo == cmd[23:16])
    else $error("echo changed without accepted position");
  chk_snap_position: assert property (
    st.phase == gmri_pkg::PH_RX ##1 st.phase == gmri_pkg::PH_LOAD
    |-> st.snap[15:0] == $past({mech.position, mech.current}))
    else $error("reported position is not the live finger state");
  chk_cmd_changes: assert property (
    $changed(cmd) |-> cmd_strobe)
    else $error("command block changed without a write");
  chk_ack_address: assert property (
    tx.valid && st.kind == gmri_pkg::RESP_WRITE && st.tx_idx == 5'h02
    |-> tx.data == st.addr[15:8] && st.tx_len == 5'h08)
    else $error("write acknowledge malformed");
  chk_crc_tail: assert property (
    tx.valid && st.tx_idx == st.tx_len - 5'h01 |-> tx.data == tx_crc[15:8])
    else $error("reply check word high byte wrong");
  chk_strobe_pulse: assert property (
    cmd_strobe |=> !cmd_strobe ##1 st.phase != gmri_pkg::PH_RX)
    else $error("command strobe longer than one cycle");
endmodule : gmri_top
`default_nettype wire

// file: hw/gmri_pkg.sv
/*
 gmri_pkg: constants and carrier types of the gripper register interface.
 Assumes one 100 MHz clock domain shared by all users of the package.
*/
package gmri_pkg;
  // framing
  localparam logic [7:0] SLAVE_ID_DEFAULT = 8'h09;
  localparam logic [7:0] FC_READ_HOLDING = 8'h03;
  localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [4:0] READ_REQ_LEN = 5'h08;
  localparam logic [4:0] WRITE_HDR_LEN = 5'h09;
  localparam logic [4:0] READ_RESP_HDR = 5'h05;
  localparam logic [4:0] WRITE_RESP_LEN = 5'h08;
  localparam logic [4:0] EXC_RESP_LEN = 5'h05;
  localparam logic [4:0] MIN_FRAME_LEN = 5'h04;
  localparam logic [4:0] DATA_FIRST_IDX = 5'h07;
  localparam logic [4:0] DATA_END_IDX = 5'h0D;
  localparam logic [4:0] IDX_MAX = 5'h1F;
  // register map
  localparam logic [15:0] CMD_BASE_ADDR = 16'h03E8;
  localparam logic [15:0] ACTION_REQUEST_OFS = 16'h03E9;
  localparam logic [15:0] POSITION_REQUEST_OFS = 16'h03EA;
  localparam logic [15:0] SPEED_FORCE_OFS = 16'h03EB;
  localparam logic [15:0] GRIPPER_STATUS_OFS = 16'h07D0;
  localparam logic [15:0] FAULT_ECHO_OFS = 16'h07D1;
  localparam logic [15:0] POSITION_CURRENT_OFS = 16'h07D2;
  localparam logic [15:0] BLOCK_WORDS = 16'h0003;
  localparam logic [15:0] CMD_RESET = 16'h0000;
  localparam logic [7:0] RESERVED_BYTE = 8'h00;
  // field positions inside the action and status bytes
  localparam int ACT_BIT = 0;
  localparam int GTO_BIT = 3;
  localparam int STA_LSB = 4;
  localparam int OBJ_LSB = 6;
  localparam logic [1:0] OBJ_MOVING = 2'h0;
  localparam logic [1:0] OBJ_CONTACT_OPEN = 2'h1;
  localparam logic [1:0] OBJ_CONTACT_CLOSE = 2'h2;
  localparam logic [1:0] OBJ_ARRIVED = 2'h3;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic frame_end;
  } gmri_rx_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } gmri_tx_t;

  typedef struct packed {
    logic [15:0] action_request_word;
    logic [15:0] position_request_word;
    logic [15:0] speed_force_word;
  } gmri_cmd_t;

  typedef struct packed {
    logic [7:0] position;
    logic [7:0] current;
    logic [7:0] fault;
    logic [1:0] activation_state;
    logic moving;
    logic contact_closing;
    logic contact_opening;
    logic arrived;
  } gmri_mech_t;

  typedef enum logic [1:0] {PH_RX, PH_LOAD, PH_SEND} gmri_phase_t;
  typedef enum logic [1:0] {RESP_READ, RESP_WRITE, RESP_EXC} gmri_resp_t;
endpackage : gmri_pkg

// file: hw/gmri_crc16.sv
/*
 gmri_crc16: running frame check over a byte stream, reflected form.
 Assumes init and update come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module gmri_crc16 (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // byte stream
  input wire logic init,
  input wire logic update,
  input wire logic [7:0] data,
  // running value
  output logic [15:0] crc
);
  typedef struct packed {
    logic [15:0] crc;
  } gmri_crc_state_t;

  gmri_crc_state_t st;
  gmri_crc_state_t next_st;

  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ gmri_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

  always_comb begin
    next_st = st;
    // init wins: a new frame never inherits old bytes
    if (init) begin
      next_st.crc = gmri_pkg::CRC_INIT;
    end else if (update) begin
      next_st.crc = crc_byte(st.crc, data);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st.crc <= gmri_pkg::CRC_INIT;
    end else begin
      st <= next_st;
    end
  end

  assign crc = st.crc;
endmodule : gmri_crc16
`default_nettype wire

// file: tb/gmri_master_model.sv
/*
 gmri_master_model: controller side of the serial link; sends whole
 request frames and collects reply bytes.
 Assumes a same-clock front end; reply bytes are taken with tx_ready.
*/
`timescale 1ns/1ps
`default_nettype none
module gmri_master_model (
  // clock
  input wire logic ref_clk,
  // request bytes
  output gmri_pkg::gmri_rx_t rx,
  // reply bytes
  input wire gmri_pkg::gmri_tx_t tx,
  input wire logic stall,
  output logic tx_ready
);
  logic [7:0] got[$];

  initial begin
    rx = '0;
    tx_ready = 1'b0;
  end

  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = gmri_pkg::CRC_INIT;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int b = 0; b < 8; b++) begin
        c = c[0] ? ((c >> 1) ^ gmri_pkg::CRC_POLY) : (c >> 1);
      end
    end
    return c;
  endfunction : crc16

  // whole frame, check word low byte first
  task automatic send_frame(input logic [7:0] q[$], input logic bad);
    logic [15:0] c;
    c = crc16(q) ^ {15'h0000, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i]) begin
      @(negedge ref_clk);
      rx.valid = 1'b1;
      rx.data = q[i];
      @(negedge ref_clk);
      rx.valid = 1'b0;
      // idle line must not look like the last byte
      rx.data = ~q[i];
    end
    @(negedge ref_clk);
    rx.frame_end = 1'b1;
    @(negedge ref_clk);
    rx.frame_end = 1'b0;
  endtask : send_frame

  // a byte shown now is taken at the next rising edge
  always @(negedge ref_clk) begin
    if (tx.valid === 1'b1 && !stall) begin
      got.push_back(tx.data);
    end
    tx_ready <= !stall;
  end
endmodule : gmri_master_model
`default_nettype wire

// file: tb/tb_gmri_top.sv
/*
 tb_gmri_top: self-checking bench for the gripper register interface.
 Assumes the master model sends frames; motion state is driven here.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  failures++; $display("unexpected %s expected %h seen %h", n, e, g); end end
module tb_gmri_top;
  localparam logic [7:0] ID = gmri_pkg::SLAVE_ID_DEFAULT;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic stall = 1'b0;
  logic slow = 1'b0;
  gmri_pkg::gmri_rx_t rx;
  gmri_pkg::gmri_tx_t tx;
  logic tx_ready;
  gmri_pkg::gmri_cmd_t cmd;
  logic cmd_strobe;
  gmri_pkg::gmri_mech_t mech = '0;
  int failures = 0;
  int samples_checked = 0;
  int strobes = 0;
  logic [31:0] seed = 32'h53BD615D;
  logic [31:0] r;
  logic [31:0] sr;
  logic [15:0] m_act = 16'h0000;
  logic [15:0] m_pos = 16'h0000;
  logic [15:0] m_sf = 16'h0000;
  logic [7:0] m_echo = 8'h00;
  logic [7:0] q[$];
  logic [7:0] e[$];

  gmri_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .rx(rx),
    .tx_ready(tx_ready), .tx(tx), .cmd(cmd), .cmd_strobe(cmd_strobe),
    .mech(mech));
  gmri_master_model mst (.ref_clk(ref_clk), .rx(rx), .tx(tx),
    .stall(stall), .tx_ready(tx_ready));

  always #5 ref_clk = ~ref_clk;

  function logic [31:0] nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : nxt

  always @(negedge ref_clk) begin
    if (cmd_strobe === 1'b1) strobes++;
    sr = nxt();
    stall <= slow & sr[0];
  end

  function automatic logic [15:0] word(input logic [15:0] a);
    logic [1:0] obj;
    logic act;
    logic gto;
    act = m_act[8];
    gto = act & m_act[11];
    obj = 2'h0;
    if (gto && !mech.moving) begin
      if (mech.arrived) obj = 2'h3;
      else if (mech.contact_closing) obj = 2'h2;
      else if (mech.contact_opening) obj = 2'h1;
    end
    case (a)
      gmri_pkg::GRIPPER_STATUS_OFS:
        return {obj, mech.activation_state, gto, 2'h0, act, 8'h00};
      gmri_pkg::FAULT_ECHO_OFS: return {mech.fault, m_echo};
      default: return {mech.position, mech.current};
    endcase
  endfunction : word

  task automatic check_reply();
    logic [15:0] c;
    int k;
    c = mst.crc16(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    k = 0;
    while (mst.got.size() < e.size() && k < 600) begin
      @(negedge ref_clk);
      k++;
    end
    if (mst.got.size() < e.size()) begin
      failures++;
      results();
    end else begin
      repeat (12) @(negedge ref_clk);
      `CHK("reply length", e.size(), mst.got.size())
      foreach (e[i]) `CHK("reply byte", e[i], mst.got[i])
    end
  endtask : check_reply

  task automatic do_read(input logic [15:0] a, input logic [15:0] n);
    logic [15:0] w;
    logic [7:0] bc;
    mst.got.delete();
    q = {ID, 8'h03, a[15:8], a[7:0], n[15:8], n[7:0]};
    mst.send_frame(q, 1'b0);
    // byte count as one queue element, not two
    bc = {n[6:0], 1'b0};
    e = {ID, 8'h03, bc};
    for (int i = 0; i < n; i++) begin
      w = word(a + i[15:0]);
      e.push_back(w[15:8]);
      e.push_back(w[7:0]);
    end
    check_reply();
  endtask : do_read

  task automatic do_write(input logic [15:0] a, p, s);
    int s0;
    s0 = strobes;
    mst.got.delete();
    q = {ID, 8'h10, 8'h03, 8'hE8, 8'h00, 8'h03, 8'h06, a[15:8], a[7:0],
      p[15:8], p[7:0], s[15:8], s[7:0]};
    mst.send_frame(q, 1'b0);
    m_act = a;
    m_pos = p;
    m_sf = s;
    m_echo = p[7:0];
    e = {ID, 8'h10, 8'h03, 8'hE8, 8'h00, 8'h03};
    check_reply();
    `CHK("action word", m_act, cmd.action_request_word)
    `CHK("position word", m_pos, cmd.position_request_word)
    `CHK("speed force word", m_sf, cmd.speed_force_word)
    `CHK("strobe count", s0 + 1, strobes)
  endtask : do_write

  task automatic no_reply(input logic bad);
    mst.got.delete();
    mst.send_frame(q, bad);
    repeat (30) @(negedge ref_clk);
    `CHK("silent frame", 0, mst.got.size())
    `CHK("position kept", m_pos, cmd.position_request_word)
  endtask : no_reply

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  initial begin
    repeat (6) @(negedge ref_clk);
    rst_n = 1'b1;
    `CHK("tx valid", 1'b0, tx.valid)
    `CHK("cmd", 48'h0, cmd)
    `CHK("strobe", 1'b0, cmd_strobe)
    $display("test 1 done");
    mech = {8'h0E, 8'h0A, 8'h00, 2'h3, 4'h8};
    do_write(16'h0900, 16'h00FF, 16'hFFFF);
    do_read(16'h07D0, 16'h0003);
    do_read(16'h07D1, 16'h0002);
    $display("test 2 done");
    mech = {8'hBD, 8'h00, 8'h00, 2'h3, 4'h4};
    do_read(16'h07D0, 16'h0003);
    $display("test 3 done");
    do_write(16'h0900, 16'h0000, 16'hFFFF);
    mech = {8'hBB, 8'h10, 8'h00, 2'h3, 4'h8};
    // read once while moving, then once more after arrival
    do_read(16'h07D0, 16'h0003);
    mech = {8'h0D, 8'h00, 8'h00, 2'h3, 4'h1};
    do_read(16'h07D0, 16'h0003);
    $display("test 4 done");
    q = {ID, 8'h10, 8'h03, 8'hE8, 8'h00, 8'h03, 8'h06, 8'h09, 8'h00,
      8'h00, 8'h55, 8'hFF, 8'hFF};
    no_reply(1'b1);
    q[0] = 8'h05;
    no_reply(1'b0);
    mst.got.delete();
    q = {ID, 8'h04, 8'h07, 8'hD0, 8'h00, 8'h03};
    mst.send_frame(q, 1'b0);
    e = {ID, 8'h84, 8'h01};
    check_reply();
    mst.got.delete();
    q = {ID, 8'h03, 8'h03, 8'hE8, 8'h00, 8'h03};
    mst.send_frame(q, 1'b0);
    e = {ID, 8'h83, 8'h02};
    check_reply();
    mst.got.delete();
    q = {ID, 8'h10, 8'h03, 8'hE9, 8'h00, 8'h03, 8'h06, 8'h09, 8'h00,
      8'h00, 8'h55, 8'hFF, 8'hFF};
    mst.send_frame(q, 1'b0);
    e = {ID, 8'h90, 8'h02};
    check_reply();
    `CHK("position kept", m_pos, cmd.position_request_word)
    $display("test 5 done");
    // slow reply side, random commands and motion state
    slow = 1'b1;
    for (int i = 0; i < 8; i++) begin
      r = nxt();
      do_write(r[15:0], {8'h00, r[23:16]}, r[31:16]);
      r = nxt();
      mech = r[29:0];
      do_read(16'h07D0, 16'h0003);
    end
    $display("test 6 done");
    results();
  end
endmodule : tb_gmri_top
`default_nettype wire
